// [rtl/port_pin_pkg.sv]
// Package: register map, field positions, reset values and carriers for the port pin block
package port_pin_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_XBAR_CFG2   = 8'h00;
    localparam logic [7:0] OFS_OUT_MODE    = 8'h04;
    localparam logic [7:0] OFS_IN_MODE     = 8'h08;
    localparam logic [7:0] OFS_DATA        = 8'h0c;
    localparam logic [7:0] OFS_DATA_LATCH  = 8'h10;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int          BIT_XBAR_EN     = 4;
    localparam int          BIT_EXTMEM_RSV  = 5;
    localparam int          BIT_PULLUP_DIS  = 7;
    localparam int          PIN_WRSTROBE    = 7;
    localparam int          PIN_RDSTROBE    = 6;
    localparam int          PIN_ALE         = 5;
    localparam logic [7:0]  RST_XBAR_CFG2   = 8'h00;
    localparam logic [31:0] RST_OUT_MODE    = 32'h0000_0000;
    localparam logic [23:0] RST_IN_MODE     = 24'hff_ffff;
    localparam logic [31:0] RST_DATA_LATCH  = 32'hffff_ffff;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        active;     // Off-chip move executing on low ports
        logic        read;       // Access is a read
        logic        muxed;      // Multiplexed address/data mode
        logic [31:0] ctl_mask;   // Pins the interface drives
        logic [31:0] data_mask;  // Data bus pins
        logic [31:0] level;      // Levels it wants on its pins
    } extmem_s;

    typedef struct packed {
        logic [31:0] alloc;      // Pin allocated to a peripheral
        logic [31:0] is_input;   // Allocated function is an input
        logic [31:0] level;      // Peripheral output level
        logic [31:0] bus_pins;   // Serial-bus data and clock pins
        logic [31:0] rx0_pin;    // Pin carrying uart0_receive
        logic [31:0] rx1_pin;    // Pin carrying uart1_receive
        logic        uart0_mode0;
        logic        uart1_mode0;
    } periph_s;

endpackage

// [rtl/port_pin_mode_control.sv]
// Per-pin mode, drive and pull-up control for four 8-bit ports with an AXI4-Lite slave
// Notes on behaviour
// - All low-port drivers stay off until crossbar_enable is set.
// - Push-pull pin drives the latch bit: 0 low, 1 high.
// - Open-drain pin drives low on 0, floats on 1.
// - One output_mode_select bit per pin: 1 push-pull, 0 open-drain.
// - All output_mode_select bits reset to 0, open-drain.
// - Drive type applies to GPIO and peripheral-owned pins alike.
// - Serial-bus pins and mode-0 UART receive pins are forced open-drain.
// - Peripheral input pins have their driver disabled automatically.
// - Pull-ups on after reset; pullup_global_disable turns all off.
// - A pin driving low has its pull-up switched off.
// - Ports 1-3 have input_mode_select: 0 analog, reset 1 digital.
// - Analog pins have no digital input; data bit reads 0.
// - Analog pins have their pull-up disabled regardless of global setting.
// - Crossbar skips analog pins when allocating peripherals.
// - extmem_low_port_reserve keeps strobes, and ALE if muxed, from peripherals.
// - Running external memory access sets its own pin levels.
// - Memory accesses keep drive type; reads disable data bus drivers.
// - Latch writes do not affect peripheral-owned pins.
// - Data reads return pin levels; latch read returns latch contents.
`timescale 1ns/1ps
module port_pin_mode_control #(
    parameter int ADDR_W = 8
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire port_pin_pkg::periph_s  periph,
    input  wire port_pin_pkg::extmem_s  extmem,
    input  wire logic [31:0]            pin_in,
    output logic [31:0]                 pin_out,
    output logic [31:0]                 pin_oe,
    output logic [31:0]                 pullup_en,
    output logic [31:0]                 xbar_skip,
    output logic [31:0]                 xbar_reserved
);

    // ----------------------------------------------------------------
    // Byte-lane merge for register writes
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]        cfg2_q;
    logic [31:0]       out_mode_q;
    logic [23:0]       in_mode_q;
    logic [31:0]       latch_q;
    logic              aw_got_q;
    logic              w_got_q;
    logic [ADDR_W-1:0] waddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic [31:0]       pin_out_q;
    logic [31:0]       pin_oe_q;
    logic [31:0]       pullup_q;

    // ----------------------------------------------------------------
    // Write path: address and data taken in either order
    // ----------------------------------------------------------------
    wire logic [ADDR_W-1:0] wa       = aw_got_q ? waddr_q : s_axi_awaddr;
    wire logic [31:0]       wd       = w_got_q ? wdata_q : s_axi_wdata;
    wire logic [3:0]        ws       = w_got_q ? wstrb_q : s_axi_wstrb;
    wire logic              aw_fire  = s_axi_awvalid & s_axi_awready;
    wire logic              w_fire   = s_axi_wvalid & s_axi_wready;
    wire logic              do_write = (aw_got_q | aw_fire) & (w_got_q | w_fire);
    wire logic              wr_cfg   = do_write && wa == ADDR_W'(port_pin_pkg::OFS_XBAR_CFG2);
    wire logic              wr_omode = do_write && wa == ADDR_W'(port_pin_pkg::OFS_OUT_MODE);
    wire logic              wr_imode = do_write && wa == ADDR_W'(port_pin_pkg::OFS_IN_MODE);
    wire logic              wr_latch = do_write && (wa == ADDR_W'(port_pin_pkg::OFS_DATA) ||
                                       wa == ADDR_W'(port_pin_pkg::OFS_DATA_LATCH));
    wire logic              wr_hit   = wr_cfg | wr_omode | wr_imode | wr_latch;

    assign s_axi_awready = ~aw_got_q & ~bvalid_q;
    assign s_axi_wready  = ~w_got_q & ~bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // Holding registers for a half-arrived write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            waddr_q  <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else begin
            aw_got_q <= ~do_write & (aw_got_q | aw_fire);
            w_got_q  <= ~do_write & (w_got_q | w_fire);
            if (aw_fire) waddr_q <= s_axi_awaddr;
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Response follows the cycle in which both halves are present
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= port_pin_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? port_pin_pkg::RESP_OKAY : port_pin_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Configuration registers; latch write is harmless on peripheral pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg2_q     <= port_pin_pkg::RST_XBAR_CFG2;
            out_mode_q <= port_pin_pkg::RST_OUT_MODE;
            in_mode_q  <= port_pin_pkg::RST_IN_MODE;
            latch_q    <= port_pin_pkg::RST_DATA_LATCH;
        end else begin
            if (wr_cfg) cfg2_q <= 8'(merge({24'h0, cfg2_q}, wd, ws));
            if (wr_omode) out_mode_q <= merge(out_mode_q, wd, ws);
            if (wr_imode) in_mode_q <= 24'(merge({8'h0, in_mode_q}, wd, ws));
            if (wr_latch) latch_q <= merge(latch_q, wd, ws);
        end
    end

    // ----------------------------------------------------------------
    // Pin decisions
    // ----------------------------------------------------------------
    wire logic        xbar_en  = cfg2_q[port_pin_pkg::BIT_XBAR_EN];
    wire logic        pud      = cfg2_q[port_pin_pkg::BIT_PULLUP_DIS];
    wire logic        rsv      = cfg2_q[port_pin_pkg::BIT_EXTMEM_RSV];
    // Port 0 has no analog function, so it is always digital
    wire logic [31:0] digital  = {in_mode_q, 8'hff};
    wire logic [31:0] force_od = periph.bus_pins |
                                 (periph.uart0_mode0 ? periph.rx0_pin : 32'h0) |
                                 (periph.uart1_mode0 ? periph.rx1_pin : 32'h0);
    wire logic [31:0] push     = out_mode_q & ~force_od;
    wire logic [31:0] mem_ctl  = extmem.active ? extmem.ctl_mask : 32'h0;
    wire logic [31:0] level    = (mem_ctl & extmem.level) |
                                 (~mem_ctl & periph.alloc & periph.level) |
                                 (~mem_ctl & ~periph.alloc & latch_q);
    wire logic [31:0] rd_off   = (extmem.active & extmem.read) ? extmem.data_mask : 32'h0;
    wire logic [31:0] may_drv  = {32{xbar_en}} &
                                 ~(periph.alloc & periph.is_input) &
                                 ~rd_off;
    // Driver on for push-pull, or open-drain pulling low
    wire logic [31:0] oe_d     = may_drv & (push | ~level);
    // Pull-up gated so an output never fights it
    wire logic [31:0] pu_d     = {32{~pud}} & digital & ~(oe_d & ~level);

    // Pin outputs come straight from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_q <= port_pin_pkg::RST_DATA_LATCH;
            pin_oe_q  <= '0;
            pullup_q  <= '1;
        end else begin
            pin_out_q <= level;
            pin_oe_q  <= oe_d;
            pullup_q  <= pu_d;
        end
    end

    assign pin_out       = pin_out_q;
    assign pin_oe        = pin_oe_q;
    assign pullup_en     = pullup_q;
    assign xbar_skip     = ~digital;
    assign xbar_reserved = {24'h0, rsv, rsv, rsv & extmem.muxed, 5'h0};

    // ----------------------------------------------------------------
    // Read path; analog pins read 0 from the pins
    // ----------------------------------------------------------------
    wire logic [31:0] pin_rd  = pin_in & digital;
    wire logic        ar_fire = s_axi_arvalid & s_axi_arready;
    wire logic [7:0]  ra      = 8'(s_axi_araddr);
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (ra)
            port_pin_pkg::OFS_XBAR_CFG2:  rd_mux = {24'h0, cfg2_q};
            port_pin_pkg::OFS_OUT_MODE:   rd_mux = out_mode_q;
            port_pin_pkg::OFS_IN_MODE:    rd_mux = {8'h0, in_mode_q};
            port_pin_pkg::OFS_DATA:       rd_mux = pin_rd;
            port_pin_pkg::OFS_DATA_LATCH: rd_mux = latch_q;
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
        if (s_axi_araddr[ADDR_W-1:0] != ADDR_W'(ra)) begin
            rd_hit = 1'b0;
            rd_mux = 32'h0;
        end
    end

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // One read in flight; data held until taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= port_pin_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_hit ? port_pin_pkg::RESP_OKAY : port_pin_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_reset_release;
        !aresetn ##1 aresetn;
    endsequence

    property p_drivers_off;
        !xbar_en |=> pin_oe == 32'h0;
    endproperty
    a_drivers_off: assert property (p_drivers_off)
        else $error("driver enabled while crossbar disabled");

    property p_push_pull;
        xbar_en && !mem_ctl[0] && !rd_off[0] && !periph.alloc[0] && push[0] |=>
            pin_oe[0] && pin_out[0] == $past(latch_q[0]);
    endproperty
    a_push_pull: assert property (p_push_pull)
        else $error("push-pull pin not following latch");

    property p_open_drain;
        xbar_en && !mem_ctl[1] && !rd_off[1] && !periph.alloc[1] && !push[1] |=>
            pin_oe[1] == !$past(latch_q[1]);
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain pin drive wrong");

    property p_reset_vals;
        @(posedge aclk) disable iff (1'b0)
        s_reset_release |-> out_mode_q == 32'h0 && latch_q == 32'hffff_ffff &&
            in_mode_q == 24'hff_ffff && pin_oe == 32'h0;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("reset values wrong");

    property p_forced_od;
        periph.bus_pins[2] && !mem_ctl[2] && level[2] |=> !pin_oe[2];
    endproperty
    a_forced_od: assert property (p_forced_od)
        else $error("serial-bus pin driven high");

    property p_input_alloc;
        periph.alloc[3] && periph.is_input[3] |=> !pin_oe[3];
    endproperty
    a_input_alloc: assert property (p_input_alloc)
        else $error("peripheral input pin driven");

    property p_pullup_global;
        pud |=> pullup_en == 32'h0;
    endproperty
    a_pullup_global: assert property (p_pullup_global)
        else $error("pull-up on while globally disabled");

    property p_pullup_low;
        pin_oe[4] && !pin_out[4] |-> !pullup_en[4];
    endproperty
    a_pullup_low: assert property (p_pullup_low)
        else $error("pull-up on while driving low");

    property p_analog_read;
        ar_fire && ra == port_pin_pkg::OFS_DATA && !in_mode_q[0] |=> !s_axi_rdata[8];
    endproperty
    a_analog_read: assert property (p_analog_read)
        else $error("analog pin read as 1");

    property p_analog_pullup;
        !in_mode_q[7] |=> !pullup_en[15];
    endproperty
    a_analog_pullup: assert property (p_analog_pullup)
        else $error("pull-up on analog pin");

    property p_mem_read;
        extmem.active && extmem.read && extmem.data_mask[0] |=> !pin_oe[0];
    endproperty
    a_mem_read: assert property (p_mem_read)
        else $error("data bus driven during memory read");

endmodule

// [bench/pin_net_model.sv]
// Model of the board wiring seen at the port pins
`timescale 1ns/1ps
module pin_net_model (
    input  wire logic        aclk,
    input  wire logic [31:0] pin_out,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] pullup_en,
    input  wire logic [31:0] ext_en,
    input  wire logic [31:0] ext_lvl,
    output logic [31:0]      pin_in
);
    logic [31:0] float_q = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Undriven lines
    // ----------------------------------------------------------------
    // Toggles so a floating pin never looks like a stable level
    always_ff @(posedge aclk) begin
        float_q <= ~float_q;
    end

    // Own driver wins, then outside driver, then pull-up, else noise
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_lvl)
                  | (~pin_oe & ~ext_en & (pullup_en | float_q));
endmodule

// [bench/port_pin_mode_control_bench.sv]
// Self-checking bench for the port pin mode control block
`timescale 1ns/1ps
module port_pin_mode_control_bench;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, pin_in, pin_out, pin_oe, pullup_en, xskip, xres;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    port_pin_pkg::periph_s periph = '0;
    port_pin_pkg::extmem_s extmem = '0;
    logic [31:0] ext_en = 32'h0, ext_lvl = 32'h0, rd, m_om, m_latch, oe_e, lvl_e, pu_e, dig;
    logic [23:0] m_im;
    logic [7:0]  m_cfg;
    logic [7:0]  ofs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
    int n_errors = 0, compares = 0, seed = 5256;

    always #5 aclk = ~aclk;

    port_pin_mode_control DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph(periph), .extmem(extmem),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .xbar_skip(xskip), .xbar_reserved(xres));

    pin_net_model net (.aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_lvl(ext_lvl), .pin_in(pin_in));

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Hang guard, far beyond the expected run length
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        close_out();
    end

    // ----------------------------------------------------------------
    // AXI4-Lite master; waits on the slave's handshakes, giving up after 200 cycles
    // ----------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid === 1'b1) && n < 200);
        resp = bresp;
        bready <= 1'b0;
        if (n >= 200) n_errors++;
        model_write(a, d, s);
    endtask

    task automatic axi_read(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid === 1'b1) && n < 200);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 200) n_errors++;
    endtask

    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) if (s[i]) o[i*8 +: 8] = d[i*8 +: 8];
        return o;
    endfunction

    // Byte merge per strobe; narrow registers keep only their width
    task automatic model_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        case (a)
            8'h00: m_cfg = 8'(merge({24'h0, m_cfg}, d, s));
            8'h04: m_om = merge(m_om, d, s);
            8'h08: m_im = 24'(merge({8'h0, m_im}, d, s));
            8'h0c, 8'h10: m_latch = merge(m_latch, d, s);
            default: ;
        endcase
    endtask

    // Expected drive, level and pull-up of every pin
    task automatic predict();
        logic [31:0] pp, am;
        pp = m_om & ~(periph.bus_pins | (periph.uart0_mode0 ? periph.rx0_pin : 32'h0)
                    | (periph.uart1_mode0 ? periph.rx1_pin : 32'h0));
        am = {32{extmem.active}} & extmem.ctl_mask;
        lvl_e = (am & extmem.level) | (~am & periph.alloc & periph.level)
              | (~am & ~periph.alloc & m_latch);
        oe_e = {32{m_cfg[4]}} & ~(periph.alloc & periph.is_input)
             & ~({32{extmem.active & extmem.read}} & extmem.data_mask) & (pp | ~lvl_e);
        dig = {m_im, 8'hff};
        pu_e = {32{~m_cfg[7]}} & dig & ~(oe_e & ~lvl_e);
    endtask

    // Pins lag registers and inputs by one registered stage
    task automatic check_pins();
        logic r;
        repeat (2) @(posedge aclk);
        #1;
        predict();
        r = m_cfg[port_pin_pkg::BIT_EXTMEM_RSV];
        check("pin_oe", pin_oe, oe_e);
        check("pin_out", pin_out, lvl_e);
        check("pullup_en", pullup_en, pu_e);
        check("xbar_skip", xskip, ~dig);
        check("xbar_reserved", xres, (32'(r) << port_pin_pkg::PIN_WRSTROBE)
            | (32'(r) << port_pin_pkg::PIN_RDSTROBE)
            | (32'(r & extmem.muxed) << port_pin_pkg::PIN_ALE));
    endtask

    // Data read gives pin level on digital pins, 0 on analog ones
    task automatic check_reads();
        logic [31:0] kn, lv;
        kn = oe_e | ext_en | pu_e | ~dig;
        lv = (oe_e & lvl_e) | (~oe_e & ext_en & ext_lvl) | (~oe_e & ~ext_en & pu_e);
        axi_read(8'h0c);
        check("data", rd & kn, lv & dig & kn);
        axi_read(8'h10);
        check("latch", rd, m_latch);
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        m_cfg = port_pin_pkg::RST_XBAR_CFG2;
        m_om = port_pin_pkg::RST_OUT_MODE;
        m_im = port_pin_pkg::RST_IN_MODE;
        m_latch = port_pin_pkg::RST_DATA_LATCH;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(8'h00);
        check("cfg2", rd, 32'h0000_0000);
        axi_read(8'h04);
        check("out_mode", rd, 32'h0000_0000);
        axi_read(8'h08);
        check("in_mode", rd, 32'h00ff_ffff);
        axi_read(8'h10);
        check("latch", rd, 32'hffff_ffff);
        check_pins();
        $display("test reset done");
        axi_write(8'h04, 32'hffff_ffff, 4'hf);
        axi_write(8'h0c, 32'h0000_0000, 4'hf);
        check_pins();
        axi_write(8'h00, 32'h0000_0010, 4'hf);
        check_pins();
        axi_write(8'h10, 32'h5a5a_a5a5, 4'hf);
        axi_write(8'h04, 32'hffff_0000, 4'hf);
        check_pins();
        $display("test drive done");
        axi_write(8'h04, 32'h0000_0000, 4'hf);
        axi_write(8'h0c, 32'hffff_ffff, 4'hf);
        axi_write(8'h08, 32'h000f_00f0, 4'hf);
        ext_en <= 32'hffff_ffff;
        ext_lvl <= 32'hffff_ffff;
        check_pins();
        check_reads();
        $display("test inputs done");
        axi_write(8'h14, 32'h1234_5678, 4'hf);
        check("bresp", 32'(resp), 32'(port_pin_pkg::RESP_SLVERR));
        axi_read(8'h14);
        check("rresp", 32'(resp), 32'(port_pin_pkg::RESP_SLVERR));
        check("rdata", rd, 32'h0);
        axi_write(8'h04, 32'hffff_ffff, 4'h5);
        axi_read(8'h04);
        check("out_mode", rd, m_om);
        $display("test errors done");
        // Strobes parked push-pull at 1, then a write access owns them
        axi_write(8'h04, 32'h0000_00c0, 4'h1);
        axi_write(8'h0c, 32'hffff_ffff, 4'hf);
        extmem <= {1'b1, 2'b00, 32'h0000_00c0, 32'h0000_0000, 32'h0000_00ff};
        check_pins();
        check("strobe_oe", pin_oe & 32'h0000_00c0, 32'h0000_00c0);
        check("strobe_out", pin_out & 32'h0000_00c0, 32'h0000_00c0);
        $display("test strobes done");
        for (int i = 0; i < 60; i++) begin
            @(posedge aclk);
            periph <= {$random(seed), $random(seed), $random(seed), $random(seed),
                       $random(seed), $random(seed), 2'($random(seed))};
            extmem <= {($random(seed) % 4 == 0), 2'($random(seed)), $random(seed),
                       $random(seed), $random(seed)};
            ext_en <= $random(seed);
            ext_lvl <= $random(seed);
            axi_write(ofs[$unsigned($random(seed)) % 6], $random(seed), 4'($random(seed)));
            check_pins();
            check_reads();
        end
        $display("test random done");
        close_out();
    end
endmodule
